// [inc/cof_pkg.sv]
// shared constants and helper functions for the configurable on-chip fifo
package cof_pkg;

  // word indices on the apb bus; byte address is four times the index
  localparam logic [5:0] IDX_DATA   = 6'h00;
  localparam logic [5:0] IDX_PKT    = 6'h01;
  localparam logic [5:0] IDX_FILL   = 6'h08;
  localparam logic [5:0] IDX_ISTAT  = 6'h09;
  localparam logic [5:0] IDX_EVENT  = 6'h0a;
  localparam logic [5:0] IDX_IEN    = 6'h0b;
  localparam logic [5:0] IDX_AFULL  = 6'h0c;
  localparam logic [5:0] IDX_AEMPTY = 6'h0d;

  // packet status word field positions
  localparam int POS_START = 0;
  localparam int POS_END   = 1;
  localparam int POS_EMPTY = 2;
  localparam int POS_CHAN  = 8;
  localparam int POS_ERR   = 16;

  // status bit positions, shared by status, event and enable registers
  localparam int ST_EMPTY  = 0;
  localparam int ST_FULL   = 1;
  localparam int ST_AEMPTY = 2;
  localparam int ST_AFULL  = 3;
  localparam int ST_OVF    = 4;
  localparam int ST_UNF    = 5;
  localparam int ST_W      = 6;

  // capacity and threshold offsets, bus width and ten-bit symbol limits
  localparam int DUAL_GUARD    = 3;
  localparam int DUAL_AF_GAP   = 4;
  localparam int SINGLE_AF_GAP = 1;
  localparam int THR_MIN       = 1;
  localparam int MM_BUS_W      = 32;
  localparam int SYM10_BITS    = 10;
  localparam int SYM10_MAX_SPB = 2;

  // storage slot of one symbol: next power of two
  function automatic int slot_w(input int bps);
    int p;
    p = 1;
    for (int i = 0; i < 8; i++) begin
      if (p < bps) p = p * 2;
    end
    return p;
  endfunction

  // symbols per beat, limited for ten-bit symbols
  function automatic int spb_eff(input int bps, input int spb);
    return (bps == SYM10_BITS && spb > SYM10_MAX_SPB) ? SYM10_MAX_SPB : spb;
  endfunction

  // streaming data width; mixed memory-mapped and streaming is fixed to the bus width
  function automatic int stream_w(input bit in_mm, input bit out_mm, input int bps,
                                  input int spb);
    return (in_mm != out_mm) ? MM_BUS_W : slot_w(bps) * spb_eff(bps, spb);
  endfunction

  // legal memory-mapped widths are 8, 16 and 32
  function automatic int mm_w_ok(input int w);
    return (w <= 8) ? 8 : (w <= 16) ? 16 : MM_BUS_W;
  endfunction

endpackage

// [rtl/cof_top.sv]
// configurable on-chip fifo with apb data and status access
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
// Operation
// - depth parameter, default sixteen entries
// - dual clock capacity is depth minus three
// - single clock mode, all ports one clock
// - dual mode: all ports still on pclk, capacity and almost-full default drop
// - status ports are slaves, input one optional
// - output status port available in dual mode
// - irq output when interrupts configured
// - storage from flops or memory, memory default
// - input mm or stream, output mm or stream
// - mm stall on full write, empty read
// - stream moves on ready and valid; source moves on valid alone without backpressure
// - mm data width 8, 16 or 32
// - mixed mm and stream fixes 32 bits
// - mm access always four bytes
// - stream symbol, beat, channel, error configurable
// - odd symbol width rounds to power two
// - ten-bit symbols allow two per beat
// - packet mode carries start, end, empty
// - offset one latches status, zero pushes
// - offset zero read pops, one reads status
// - event bit sticky until one written
// - irq on event rise with mask set
module cof_top
  import cof_pkg::*;
#(
  parameter int  DEPTH     = 16,
  parameter bit  DUAL_MODE = 1'b0,
  parameter bit  IN_MM     = 1'b1,
  parameter bit  OUT_MM    = 1'b0,
  parameter bit  USE_RAM   = 1'b1,
  parameter bit  BACKPRESS = 1'b1,
  parameter bit  PKT_EN    = 1'b1,
  parameter bit  IN_STAT   = 1'b1,
  parameter bit  OUT_STAT  = 1'b0,
  parameter bit  IRQ_EN    = 1'b1,
  parameter int  MM_W      = 32,
  parameter int  BPS       = 8,
  parameter int  SPB       = 4,
  parameter int  CHAN_W    = 5,
  parameter int  ERR_W     = 3,
  parameter int  EMPTY_W   = 2,
  localparam int SW        = stream_w(IN_MM, OUT_MM, BPS, SPB)
) (
  input  wire logic              pclk,        // bus and fifo clock
  input  wire logic              presetn,     // async reset, low active
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb access phase
  input  wire logic              pwrite,      // apb direction
  input  wire logic [7:0]        paddr,       // apb byte address
  input  wire logic [31:0]       pwdata,      // apb write data
  output logic      [31:0]       prdata,      // apb read data
  output logic                   pready,      // apb ready, low stalls
  output logic                   pslverr,     // apb error on unmapped
  input  wire logic              snk_valid,   // stream in valid
  input  wire logic [SW-1:0]     snk_data,    // stream in data
  input  wire logic              snk_packet_start_flag, // stream in start
  input  wire logic              snk_packet_end_flag,   // stream in end
  input  wire logic [EMPTY_W-1:0] snk_empty,  // stream in empty symbols
  input  wire logic [CHAN_W-1:0] snk_channel, // stream in channel
  input  wire logic [ERR_W-1:0]  snk_error,   // stream in error
  output logic                   snk_ready,   // stream in ready
  output logic                   src_valid,   // stream out valid
  output logic      [SW-1:0]     src_data,    // stream out data
  output logic                   src_packet_start_flag, // stream out start
  output logic                   src_packet_end_flag,   // stream out end
  output logic      [EMPTY_W-1:0] src_empty,  // stream out empty symbols
  output logic      [CHAN_W-1:0] src_channel, // stream out channel
  output logic      [ERR_W-1:0]  src_error,   // stream out error
  input  wire logic              src_ready,   // stream out ready
  output logic                   irq          // status interrupt, high
);

  // entry data width; a bus side facing a stream side is always a full word
  localparam bit MIXED = (IN_MM != OUT_MM);
  localparam int EW    = MIXED ? MM_BUS_W : (IN_MM && OUT_MM) ? mm_w_ok(MM_W) : SW;

  // entry layout: packet fields ride above the data word
  localparam int PKW   = ERR_W + CHAN_W + EMPTY_W + 2;
  localparam int ENW   = PKW + EW;

  // pointer and level widths; the level needs one bit more than a pointer at power-of-two depths from two up
  localparam int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW    = $clog2(DEPTH + 1);

  // dual mode keeps three spare slots that a clock crossing would need
  localparam int CAP   = DUAL_MODE ? DEPTH - DUAL_GUARD : DEPTH;
  localparam int AF_DEF = DUAL_MODE ? DEPTH - DUAL_AF_GAP : DEPTH - SINGLE_AF_GAP;
  localparam bit HAS_STAT = IN_STAT || (DUAL_MODE && OUT_STAT);

  // all state but the storage array in one record, filled by one process and registered by another
  typedef struct packed {
    logic [AW-1:0]   wptr;
    logic [AW-1:0]   rptr;
    logic [LW-1:0]   cnt;
    logic            hd_v;
    logic [ENW-1:0]  hd;
    logic [PKW-1:0]  last;
    logic [PKW-1:0]  pk;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            snk_ready;
    logic [ST_W-1:0] evt;
    logic [ST_W-1:0] ien;
    logic [ST_W-1:0] pend;
    logic            irq;
    logic [LW-1:0]   af;
    logic [LW-1:0]   ae;
  } cof_state_t;

  // present and next state
  cof_state_t state_r;
  cof_state_t state_nxt;

  // storage array and the push strobe that writes it
  logic [ENW-1:0] mem_r [DEPTH];
  logic           push;
  logic [ENW-1:0] push_entry;

  // pointer step with wrap for any depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // packet fields to the status word layout
  function automatic logic [31:0] pkt_word(input logic [PKW-1:0] pk);
    logic [31:0] w;
    w = '0;
    w[POS_START] = pk[0];
    w[POS_END] = pk[1];
    w[POS_EMPTY +: EMPTY_W] = pk[2 +: EMPTY_W];
    w[POS_CHAN +: CHAN_W] = pk[2 + EMPTY_W +: CHAN_W];
    w[POS_ERR +: ERR_W] = pk[2 + EMPTY_W + CHAN_W +: ERR_W];
    return w;
  endfunction

  // status word layout to packet fields
  function automatic logic [PKW-1:0] word_pkt(input logic [31:0] w);
    return {w[POS_ERR +: ERR_W], w[POS_CHAN +: CHAN_W], w[POS_EMPTY +: EMPTY_W],
            w[POS_END], w[POS_START]};
  endfunction

  // entries held: storage count plus the head register
  function automatic logic [LW:0] fill_of(input logic [LW-1:0] c, input logic v);
    return (LW + 1)'(c) + (LW + 1)'(v);
  endfunction

  // no room left for another entry
  function automatic logic at_cap(input logic [LW:0] f);
    return f >= (LW + 1)'(CAP);
  endfunction

  // threshold clamp; out-of-range writes take the nearest limit
  function automatic logic [LW-1:0] clampv(input logic [31:0] v, input int hi);
    if (v < 32'(THR_MIN)) return LW'(THR_MIN);
    if (v > 32'(hi)) return LW'(hi);
    return LW'(v);
  endfunction

  // next-state logic: bus, push, pop, head refill, status
  always_comb begin
    logic [5:0]      idx;
    logic            acc;
    logic            done;
    logic            err;
    logic            pop;
    logic            ovf;
    logic            unf;
    logic [LW:0]     fill;
    logic [LW:0]     fill_n;
    logic [ST_W-1:0] ist;
    logic [ST_W-1:0] clr;
    logic [ST_W-1:0] rise;
    idx        = paddr[7:2];
    acc        = psel && penable && !state_r.pready;
    done       = 1'b0;
    err        = 1'b0;
    pop        = 1'b0;
    ovf        = 1'b0;
    unf        = 1'b0;
    clr        = '0;
    push       = 1'b0;
    push_entry = '0;
    state_nxt  = state_r;
    fill       = fill_of(state_r.cnt, state_r.hd_v);
    fill_n     = '0;
    ist        = '0;
    rise       = '0;
    state_nxt.pready  = 1'b0;
    state_nxt.pslverr = 1'b0;

    // apb access: one wait state, more while a data access must stall
    if (acc) begin
      done = 1'b1;
      if (idx == IDX_DATA && pwrite && IN_MM) begin
        if (at_cap(fill)) begin
          if (BACKPRESS) done = 1'b0;
          else ovf = 1'b1;
        end else begin
          push = 1'b1;
          push_entry = {state_r.pk, EW'(pwdata)};
        end
      end else if (idx == IDX_DATA && !pwrite && OUT_MM) begin
        if (!state_r.hd_v) begin
          if (BACKPRESS) done = 1'b0;
          else unf = 1'b1;
          state_nxt.prdata = '0;
        end else begin
          pop = 1'b1;
          state_nxt.prdata = 32'(state_r.hd[EW-1:0]);
          state_nxt.last = state_r.hd[EW +: PKW];
        end
      end else if (idx == IDX_PKT && PKT_EN && pwrite && IN_MM) begin
        state_nxt.pk = word_pkt(pwdata);
      end else if (idx == IDX_PKT && PKT_EN && !pwrite && (IN_MM || OUT_MM)) begin
        state_nxt.prdata = pkt_word(OUT_MM ? state_r.last : state_r.pk);
      end else if (HAS_STAT && idx == IDX_FILL && !pwrite) begin
        state_nxt.prdata = 32'(fill);
      end else if (HAS_STAT && idx == IDX_ISTAT && !pwrite) begin
        state_nxt.prdata = 32'({state_r.evt & '0});
      end else if (HAS_STAT && idx == IDX_EVENT) begin
        if (pwrite) clr = pwdata[ST_W-1:0];
        else state_nxt.prdata = 32'(state_r.evt);
      end else if (HAS_STAT && idx == IDX_IEN) begin
        if (pwrite) state_nxt.ien = pwdata[ST_W-1:0];
        else state_nxt.prdata = 32'(state_r.ien);
      end else if (HAS_STAT && idx == IDX_AFULL) begin
        if (pwrite) state_nxt.af = clampv(pwdata, AF_DEF);
        else state_nxt.prdata = 32'(state_r.af);
      end else if (HAS_STAT && idx == IDX_AEMPTY) begin
        if (pwrite) state_nxt.ae = clampv(pwdata, AF_DEF);
        else state_nxt.prdata = 32'(state_r.ae);
      end else begin
        err = 1'b1;
        state_nxt.prdata = '0;
      end
      state_nxt.pready  = done;
      state_nxt.pslverr = done && err;
    end

    // streaming sink: take a beat only on valid with ready
    if (!IN_MM && snk_valid && state_r.snk_ready) begin
      if (at_cap(fill)) ovf = 1'b1;
      else begin
        push = 1'b1;
        push_entry = {snk_error, snk_channel, snk_empty, snk_packet_end_flag,
                      snk_packet_start_flag, EW'(snk_data)};
      end
    end

    // without packet support the packet fields are stored as zero
    if (!PKT_EN) push_entry[EW +: PKW] = '0;

    // streaming source: head leaves on valid with ready, or on valid alone without backpressure
    if (!OUT_MM && state_r.hd_v && (src_ready || !BACKPRESS)) pop = 1'b1;

    // storage write side
    if (push) begin
      state_nxt.wptr = ptr_inc(state_r.wptr);
    end

    // a pop frees the head register for a refill in the same cycle
    if (pop) state_nxt.hd_v = 1'b0;

    // head refill from storage; a fresh push lands a cycle later
    if (!state_nxt.hd_v && state_r.cnt != '0) begin
      state_nxt.hd_v = 1'b1;
      state_nxt.hd   = mem_r[state_r.rptr];
      state_nxt.rptr = ptr_inc(state_r.rptr);
      state_nxt.cnt  = LW'(state_r.cnt - 1'b1);
    end

    // count a push after the refill so both can meet in one cycle
    if (push) state_nxt.cnt = LW'(state_nxt.cnt + 1'b1);

    // ready is registered, so it looks at the fill after this edge
    fill_n = fill_of(state_nxt.cnt, state_nxt.hd_v);
    state_nxt.snk_ready = !BACKPRESS || !at_cap(fill_n);

    // instantaneous status from the present fill
    ist = '0;
    ist[ST_EMPTY]  = (fill == '0);
    ist[ST_FULL]   = at_cap(fill);
    ist[ST_AEMPTY] = (fill < (LW + 1)'(state_r.ae));
    ist[ST_AFULL]  = (fill > (LW + 1)'(state_r.af));
    ist[ST_OVF]    = ovf;
    ist[ST_UNF]    = unf;
    if (HAS_STAT && acc && idx == IDX_ISTAT && !pwrite) state_nxt.prdata = 32'(ist);

    // sticky events: a set in the clearing cycle wins
    state_nxt.evt = (state_r.evt & ~clr) | ist;
    rise = ist & ~state_r.evt;
    state_nxt.pend = (state_r.pend | (rise & state_nxt.ien))
                     & state_nxt.evt & state_nxt.ien;
    state_nxt.irq = IRQ_EN && HAS_STAT && (|state_nxt.pend);
  end

  // single state register; all ports share pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r           <= '0;
      state_r.snk_ready <= 1'b1;
      state_r.af        <= LW'(AF_DEF);
      state_r.ae        <= LW'(THR_MIN);
    end else begin
      state_r <= state_nxt;
    end
  end

  // storage: memory style has no reset so it maps to a block array
  generate
    if (USE_RAM) begin : g_ram
      always_ff @(posedge pclk) begin
        if (push) mem_r[state_r.wptr] <= push_entry;
      end
    end else begin : g_flop
      // flop style clears every slot at reset; costly for a deep fifo
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
        end else if (push) begin
          mem_r[state_r.wptr] <= push_entry;
        end
      end
    end
  endgenerate

  // outputs straight from the state register
  assign prdata    = state_r.prdata;
  assign pready    = state_r.pready;
  assign pslverr   = state_r.pslverr;
  assign snk_ready = state_r.snk_ready;

  // stream source: head entry fields, valid held low on a bus output
  assign src_valid = OUT_MM ? 1'b0 : state_r.hd_v;
  assign src_data  = SW'(state_r.hd[EW-1:0]);
  assign src_packet_start_flag = state_r.hd[EW];
  assign src_packet_end_flag   = state_r.hd[EW + 1];
  assign src_empty   = state_r.hd[EW + 2 +: EMPTY_W];
  assign src_channel = state_r.hd[EW + 2 + EMPTY_W +: CHAN_W];
  assign src_error   = state_r.hd[EW + 2 + EMPTY_W + CHAN_W +: ERR_W];
  assign irq         = state_r.irq;

endmodule

// [verification/cof_chk.sv]
// port-level assertions for the on-chip fifo, bound into its top module
`timescale 1ns/1ns
module cof_chk #(
  parameter int SW     = 32,
  parameter int CHAN_W = 5
) (
  input wire logic              pclk,        // clock
  input wire logic              presetn,     // async reset, low active
  input wire logic              psel,        // apb select
  input wire logic              penable,     // apb access phase
  input wire logic              pwrite,      // apb direction
  input wire logic [31:0]       prdata,      // apb read data
  input wire logic              pready,      // apb ready
  input wire logic              pslverr,     // apb error
  input wire logic              src_valid,   // stream out valid
  input wire logic              src_ready,   // stream out ready
  input wire logic [SW-1:0]     src_data,    // stream out data
  input wire logic [CHAN_W-1:0] src_channel, // stream out channel
  input wire logic              irq          // status interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // an offered beat may not change until the sink takes it
  property p_src_hold;
    src_valid && !src_ready |=> src_valid && $stable(src_data) && $stable(src_channel);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("beat changed while stalled");

  // valid only drops when the offered beat was taken
  property p_src_pop;
    $fell(src_valid) |-> $past(src_ready);
  endproperty
  a_src_pop: assert property (p_src_pop) else $error("valid dropped without a pop");

  // nothing offered, answered or raised at reset release
  property p_reset_quiet;
    $rose(presetn) |-> !src_valid && !pready && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset");

  // ready only ends a held access phase
  property p_ready_in_access;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");

  // one word per access, so ready is a single pulse
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");

  // error is only reported as the access ends
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  // refused accesses return zero data
  property p_err_data;
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refused read returned data");

  // irq drops only after a bus write clears an event or enable
  property p_irq_fall;
    $fell(irq) |-> $past(psel && pwrite, 1) || $past(psel && pwrite, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");

  c_pop: cover property (src_valid && src_ready);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_stall: cover property (psel && penable && !pready ##5 psel && penable && !pready);
endmodule

bind cof_top cof_chk #(.SW(SW), .CHAN_W(CHAN_W)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .src_valid, .src_ready, .src_data, .src_channel, .irq);

// [verification/cof_sink_model.sv]
// far-side stream sink: stalls at random, or fully while the bench holds it
`timescale 1ns/1ns
module cof_sink_model (
  input  wire logic pclk,     // clock
  input  wire logic presetn,  // async reset, low active
  input  wire logic hold,     // bench asks for a full stall
  output logic      src_ready // sink accepts a beat
);
  // random gaps so beats must wait; a beat moves only with valid too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ready <= 1'b0;
    end else begin
      src_ready <= !hold && ($urandom_range(0, 3) != 0);
    end
  end
endmodule

// [verification/tb_top.sv]
// self-checking bench: apb pushes packets, stream side drains them
`timescale 1ns/1ns
module tb_top;
  import cof_pkg::*;
  localparam int DEPTH = 16;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, hold, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, snk_data, src_data, pk;
  logic        snk_valid, snk_ready, src_valid, src_ready;
  logic        snk_packet_start_flag, snk_packet_end_flag;
  logic        src_packet_start_flag, src_packet_end_flag;
  logic [1:0]  snk_empty, src_empty;
  logic [4:0]  snk_channel, src_channel;
  logic [2:0]  snk_error, src_error;
  logic [43:0] exp_q[$];
  int          failures, samples_checked, lat, len;

  cof_top #(.DEPTH(DEPTH)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .snk_valid, .snk_data, .snk_packet_start_flag,
    .snk_packet_end_flag, .snk_empty, .snk_channel, .snk_error, .snk_ready, .src_valid,
    .src_data, .src_packet_start_flag, .src_packet_end_flag, .src_empty, .src_channel,
    .src_error, .src_ready, .irq);
  cof_sink_model u_sink (.pclk, .presetn, .hold, .src_ready);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // sink inputs are ignored with a bus input side; keep them moving anyway
  always @(posedge pclk) begin
    {snk_valid, snk_packet_start_flag, snk_packet_end_flag} <= 3'($urandom);
    {snk_empty, snk_channel, snk_error} <= 10'($urandom);
    snk_data <= $urandom;
  end

  task automatic check(input logic [43:0] got, input logic [43:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected beat: packet fields above the data word
  function automatic logic [43:0] beat(input logic [31:0] p, input logic [31:0] d);
    return {p[18:16], p[12:8], p[3:2], p[1], p[0], d};
  endfunction

  // one apb transfer; waits for ready with a bound, never a fixed count
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    lat = 0;
    do begin
      @(posedge pclk);
      lat++;
    end while (pready !== 1'b1 && lat < 500);
    if (lat >= 500) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, idx, 32'h0000_0000);
    check(44'(rd & m), 44'(e));
  endtask

  task automatic push(input logic [31:0] p, input logic [31:0] d);
    exp_q.push_back(beat(p, d));
    apb(1'b1, IDX_DATA, d);
  endtask

  task automatic drain;
    for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge pclk);
    check(44'(exp_q.size()), 44'h0);
  endtask

  // closing point for the run, also used by the watchdog
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // every beat taken by the sink must be the oldest one pushed
  always @(posedge pclk) begin
    if (presetn === 1'b1 && src_valid === 1'b1 && src_ready === 1'b1) begin
      check({src_error, src_channel, src_empty, src_packet_end_flag, src_packet_start_flag,
        src_data}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, hold} = 5'b00000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(29));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(IDX_FILL, 32'hffff_ffff, 32'h0000_0000);
    rchk(IDX_ISTAT, 32'h0000_003f, 32'h0000_0005);
    rchk(IDX_AFULL, 32'hffff_ffff, 32'(DEPTH - SINGLE_AF_GAP));
    check(44'(snk_ready), 44'h1);
    $display("test reset done");
    // random packets, the status word rewritten before each beat
    for (int p = 0; p < 4; p++) begin
      len = 1 + $urandom_range(0, 4);
      for (int i = 0; i < len; i++) begin
        pk = $urandom & 32'h0007_1f0c;
        pk[0] = (i == 0);
        pk[1] = (i == len - 1);
        apb(1'b1, IDX_PKT, pk);
        push(pk, $urandom);
      end
    end
    drain();
    $display("test packets done");
    // fill to full with the sink stalled, then a write that must wait
    hold <= 1'b1;
    apb(1'b1, IDX_IEN, 32'h0000_0002);
    apb(1'b1, IDX_EVENT, 32'h0000_003f);
    pk = 32'h0000_0000;
    apb(1'b1, IDX_PKT, pk);
    rchk(IDX_FILL, 32'hffff_ffff, 32'h0000_0000);
    for (int i = 0; i < DEPTH; i++) push(pk, $urandom);
    rchk(IDX_FILL, 32'hffff_ffff, 32'(DEPTH));
    rchk(IDX_ISTAT, 32'h0000_0002, 32'h0000_0002);
    check(44'(irq), 44'h1);
    check(44'(snk_ready), 44'h0);
    fork
      begin
        repeat (20) @(posedge pclk);
        hold <= 1'b0;
      end
    join_none
    push(pk, $urandom);
    check(44'(lat >= 20), 44'h1);
    drain();
    rchk(IDX_EVENT, 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, IDX_EVENT, 32'h0000_0002);
    rchk(IDX_EVENT, 32'h0000_0002, 32'h0000_0000);
    check(44'(irq), 44'h0);
    $display("test full and events done");
    // unmapped index and a data read on a stream output are refused
    apb(1'b1, 6'h0f, 32'h0000_1234);
    check(44'(err), 44'h1);
    apb(1'b0, IDX_DATA, 32'h0000_0000);
    check(44'(err), 44'h1);
    $display("test refusals done");
    // a reset with entries stored must leave the fifo empty
    hold <= 1'b1;
    for (int i = 0; i < 3; i++) push(pk, $urandom);
    presetn <= 1'b0;
    exp_q.delete();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    hold <= 1'b0;
    rchk(IDX_FILL, 32'hffff_ffff, 32'h0000_0000);
    check(44'(src_valid), 44'h0);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
